// ===== common/fil_pkg.sv
package fil_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned REF_HZ         = 20_000_000;
    localparam int unsigned IDLE_HZ        = 1_000_000;
    // reference edges per idle half period
    localparam int unsigned IDLE_HALF      = REF_HZ / (2 * IDLE_HZ);
    // activity timeout, in ns
    localparam int unsigned ACT_TMO_NS     = 400;
    // light timeout, in ns
    localparam int unsigned LIGHT_TMO_NS   = 5000;
    localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
    localparam int unsigned ACT_TMO_CYC    = ACT_TMO_NS / CLK_PERIOD_NS;
    localparam int unsigned LIGHT_TMO_CYC  = LIGHT_TMO_NS / CLK_PERIOD_NS;
    // high-pass filter: pulses shorter than this are transitions
    localparam int unsigned HPF_MAX_CYC    = 4000;

    localparam int unsigned CNT_W          = 13;
    localparam logic [2:0]  TEST_RESET     = 3'h0;
    localparam logic [2:0]  TEST_NORMAL    = 3'h7;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       tx_data;
        logic       tx_idle_wave;
        logic       fiber_tx;
        logic       active;
        logic       light_ok;
        logic [2:0] test_mode;
    } fil_out_t;

    typedef struct packed {
        logic [1:0]       ref_sync;
        logic [1:0]       tp_sync;
        logic [1:0]       rx_sync;
        logic             ref_last;
        logic             rx_last;
        logic [4:0]       div_cnt;
        logic             idle_wave;
        logic [CNT_W-1:0] hpf_cnt;
        fil_out_t         out;
    } fil_state_t;

endpackage

// ===== logic/fil_retrig.sv
module fil_retrig #(
    parameter int unsigned CNT_W = 13,
    parameter int unsigned LIMIT = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // trigger
    input  wire logic             trig,
    // status
    output logic                  alive
);
    localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             alive;
    } fil_retrig_t;

    fil_retrig_t st;
    fil_retrig_t next_st;

    // ------------------------------------------------------------
    // retriggerable timeout
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (trig) begin
            next_st.cnt   = '0;
            next_st.alive = 1'b1;
        end else if (st.cnt >= LIM) begin
            next_st.alive = 1'b0;
        end else begin
            next_st.cnt = st.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{cnt: LIM, alive: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign alive = st.alive;
endmodule

// ===== logic/fil_top.sv
module fil_top (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // reference and repeater side
    input  wire logic       ref_clk_in,
    input  wire logic       tp_tx_in,
    // fiber side
    input  wire logic       fiber_rx_in,
    output logic            fiber_tx_out,
    // repeater control and indicators
    output logic            test_mode_pin_0,
    output logic            test_mode_pin_1,
    output logic            test_mode_pin_2,
    output logic            low_light_indicator,
    output logic            tx_active
);
    fil_pkg::fil_state_t st;
    fil_pkg::fil_state_t next_st;
    logic                ref_rise;
    logic                tp_edge;
    logic                rx_edge;
    logic                rx_pass;
    logic                act_alive;
    logic                light_alive;

    // ------------------------------------------------------------
    // edge events
    // ------------------------------------------------------------
    assign ref_rise = st.ref_sync[1] & ~st.ref_last;
    assign tp_edge  = st.tp_sync[1] ^ st.out.tx_data;
    assign rx_edge  = st.rx_sync[1] ^ st.rx_last;
    assign rx_pass  = rx_edge && (st.hpf_cnt < fil_pkg::CNT_W'(fil_pkg::HPF_MAX_CYC));

    // ------------------------------------------------------------
    // detectors
    // ------------------------------------------------------------
    fil_retrig #(
        .CNT_W (fil_pkg::CNT_W),
        .LIMIT (fil_pkg::ACT_TMO_CYC)
    ) u_act (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .trig     (tp_edge),
        .alive    (act_alive)
    );

    fil_retrig #(
        .CNT_W (fil_pkg::CNT_W),
        .LIMIT (fil_pkg::LIGHT_TMO_CYC)
    ) u_light (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .trig     (rx_pass),
        .alive    (light_alive)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ref_sync = {st.ref_sync[0], ref_clk_in};
        next_st.tp_sync  = {st.tp_sync[0], tp_tx_in};
        next_st.rx_sync  = {st.rx_sync[0], fiber_rx_in};
        next_st.ref_last = st.ref_sync[1];
        next_st.rx_last  = st.rx_sync[1];
        next_st.out.tx_data = st.tp_sync[1];
        if (ref_rise) begin
            if (st.div_cnt == 5'(fil_pkg::IDLE_HALF - 1)) begin
                next_st.div_cnt   = '0;
                next_st.idle_wave = ~st.idle_wave;
            end else begin
                next_st.div_cnt = st.div_cnt + 5'h01;
            end
        end
        // pulse width counter, saturating; long levels are blocked
        if (rx_edge) begin
            next_st.hpf_cnt = '0;
        end else if (st.hpf_cnt != {fil_pkg::CNT_W{1'b1}}) begin
            next_st.hpf_cnt = st.hpf_cnt + fil_pkg::CNT_W'(1);
        end
        next_st.out.active       = act_alive;
        next_st.out.tx_idle_wave = st.idle_wave;
        next_st.out.fiber_tx     = act_alive ? st.out.tx_data : st.idle_wave;
        next_st.out.light_ok     = light_alive;
        next_st.out.test_mode    = light_alive ? fil_pkg::TEST_NORMAL
                                               : fil_pkg::TEST_RESET;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign fiber_tx_out        = st.out.fiber_tx;
    assign test_mode_pin_0     = st.out.test_mode[0];
    assign test_mode_pin_1     = st.out.test_mode[1];
    assign test_mode_pin_2     = st.out.test_mode[2];
    assign low_light_indicator = st.out.light_ok;
    assign tx_active           = st.out.active;
endmodule

// ===== dv/fil_top_assertions.sv
module fil_top_assertions (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ref_clk_in,
    input wire logic tp_tx_in,
    input wire logic fiber_rx_in,
    input wire logic fiber_tx_out,
    input wire logic test_mode_pin_0,
    input wire logic test_mode_pin_1,
    input wire logic test_mode_pin_2,
    input wire logic low_light_indicator,
    input wire logic tx_active
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        rq, tq, oq;
    logic [12:0] rc, tc, oc, ic;
    // stable-cycle counters
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            {rq, tq, oq, rc, tc, oc, ic} <= '0;
        end else begin
            {rq, tq, oq} <= {fiber_rx_in, tp_tx_in, fiber_tx_out};
            rc <= (fiber_rx_in != rq) ? '0 : rc + 13'(rc < 13'h1F40);
            tc <= (tp_tx_in != tq) ? '0 : tc + 13'(tc < 13'h1F40);
            oc <= (fiber_tx_out != oq) ? '0 : oc + 13'(oc < 13'h1F40);
            ic <= tx_active ? '0 : ic + 13'(ic < 13'h1F40);
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_pins_follow_light: assert property ({test_mode_pin_2, test_mode_pin_1,
        test_mode_pin_0} == {3{low_light_indicator}}) else $error("pins wrong");
    a_dark_goes_off: assert property (rc > 13'h3FC |-> !low_light_indicator)
        else $error("indicator stuck on");
    a_edge_lights: assert property (fiber_rx_in != rq && rc < 13'hF3C
        |-> ##[1:12] low_light_indicator) else $error("indicator not on");
    a_long_refused: assert property (fiber_rx_in != rq && rc > 13'hFAA
        && !low_light_indicator |-> ##1 !low_light_indicator[*8]) else $error("hpf");
    a_act_rises: assert property (tp_tx_in != tq |-> ##[1:8] tx_active)
        else $error("no activity");
    a_act_drops: assert property (tc > 13'h05F |-> !tx_active)
        else $error("activity stuck");
    a_data_routed: assert property (tx_active && tc > 13'h006 && tc < 13'h03C
        |-> fiber_tx_out == tp_tx_in) else $error("data not routed");
    a_idle_period: assert property (ic > 13'h0FA && fiber_tx_out != oq
        |-> oc inside {[13'h062:13'h064]}) else $error("idle period");
    cover property (fiber_rx_in != rq && rc > 13'hFAA);
    cover property ($fell(low_light_indicator));
    cover property ($fell(tx_active));
endmodule

// ===== dv/fil_far.sv
module fil_far (
    input wire logic core_clk,
    input wire logic light,
    output logic     ref_clk_in,
    output logic     fiber_rx_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [6:0] c;
    logic [2:0] r;
    initial {c, r, ref_clk_in, fiber_rx_in} = '0;
    // 20 MHz reference, 1 MHz far idle while lit
    always @(posedge core_clk) begin
        r <= (r == 3'h4) ? 3'h0 : r + 3'h1;
        ref_clk_in <= (r == 3'h4) ? !ref_clk_in : ref_clk_in;
        c <= (light && c != 7'h63) ? c + 7'h1 : 7'h0;
        fiber_rx_in <= (light && c == 7'h63) ? !fiber_rx_in : fiber_rx_in;
    end
endmodule

// ===== dv/fil_top_tb.sv
module fil_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst_b = 0, tp_tx_in = 0, light = 0;
    logic ref_clk_in, fiber_rx_in, fiber_tx_out, tm0, tm1, tm2, ind, tx_active;
    int   err_total = 0, checks = 0;
    fil_far fil_far_inst (.core_clk(core_clk), .light(light), .ref_clk_in(ref_clk_in),
        .fiber_rx_in(fiber_rx_in));
    fil_top fil_top_inst (.core_clk(core_clk), .rst_b(rst_b), .ref_clk_in(ref_clk_in),
        .tp_tx_in(tp_tx_in), .fiber_rx_in(fiber_rx_in), .fiber_tx_out(fiber_tx_out),
        .test_mode_pin_0(tm0), .test_mode_pin_1(tm1), .test_mode_pin_2(tm2),
        .low_light_indicator(ind), .tx_active(tx_active));
    initial forever #2.5 core_clk = !core_clk;
    // ----
    // tasks
    // ----
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waits n rising edges, then settles to the falling edge before any look
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic t_light(input int dark);
        @(posedge core_clk);
        light <= 0;
        wt(dark);
        chk({tm2, tm1, tm0}, 3'h0);
        chk({2'h0, ind}, 3'h0);
        @(posedge core_clk);
        light <= 1;
        wt(130);
        chk({tm2, tm1, tm0}, 3'h7);
    endtask
    task automatic t_hpf;
        @(posedge core_clk);
        light <= 0;
        wt(4500);
        @(posedge core_clk);
        light <= 1;
        wt(130);
        chk({2'h0, ind}, 3'h0);
        wt(100);
        chk({2'h0, ind}, 3'h1);
    endtask
    // mid-run reset: all outputs low while held
    task automatic t_rst;
        @(posedge core_clk);
        rst_b <= 0;
        wt(2);
        chk({tm2, tm1, tm0}, 3'h0);
        chk({2'h0, ind}, 3'h0);
        chk({1'b0, tx_active, fiber_tx_out}, 3'h0);
        @(posedge core_clk);
        rst_b <= 1;
        wt(200);
        chk({tm2, tm1, tm0}, 3'h7);
    endtask
    task automatic t_tx;
        repeat (20) begin
            @(posedge core_clk);
            tp_tx_in <= !tp_tx_in;
        end
        @(posedge core_clk);
        tp_tx_in <= 1;
        wt(10);
        chk({1'b0, tx_active, fiber_tx_out}, 3'h3);
        wt(120);
        chk({2'h0, tx_active}, 3'h0);
    endtask
    task automatic t_wave;
        logic v;
        int   n;
        n = 0;
        v = fiber_tx_out;
        repeat (400) begin
            @(negedge core_clk);
            n += int'(fiber_tx_out !== v);
            v = fiber_tx_out;
        end
        chk(3'(n), 3'h4);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1;
        t_light(2);
        t_light(1100);
        t_hpf;
        t_rst;
        t_tx;
        t_wave;
        report_and_stop;
    end
    initial begin
        wt(20000);
        err_total++;
        report_and_stop;
    end
endmodule
bind fil_top fil_top_assertions fil_top_assertions_inst (.core_clk(core_clk), .rst_b(rst_b),
    .ref_clk_in(ref_clk_in), .tp_tx_in(tp_tx_in), .fiber_rx_in(fiber_rx_in),
    .fiber_tx_out(fiber_tx_out), .test_mode_pin_0(test_mode_pin_0),
    .test_mode_pin_1(test_mode_pin_1), .test_mode_pin_2(test_mode_pin_2),
    .low_light_indicator(low_light_indicator), .tx_active(tx_active));
